// >>> hdl/ocd_top.sv
/*
  Operation command decoder of an eight-level interrupt controller. It takes
  the mask word, the priority and end-of-service word and the status and mode
  word from the host port, keeps the mask, rotation, read-select, poll and
  special mask state, and returns status or poll data on host reads.
  Assumes host port inputs synchronous to ref_clk, an initialization sequencer
  outside that raises init_done, and request and in-service registers outside
  that act on the in-service clear pulses and the rotation outputs.
*/
`timescale 1ns/1ps
module ocd_top #(
  parameter int N_LEVELS = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host port.
  input wire logic chip_sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic register_select,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic dout_oe,
  // Neighbouring blocks.
  input wire logic init_done,
  input wire logic [7:0] pending_req_reg,
  input wire logic [7:0] in_service_reg,
  // Controls driven into the rest of the controller.
  output logic [7:0] interrupt_mask_word,
  output logic [7:0] masked_requests,
  output logic [7:0] in_service_clear,
  output logic [2:0] lowest_prio,
  output logic rotate_on_auto_eos,
  output logic special_mask_mode,
  output logic poll_mode
);

  // The command words are eight bits wide, so only eight levels are served.
  initial begin
    if (N_LEVELS != ocd_pkg::DATA_W) begin
      $error("ocd_top: N_LEVELS must equal the data width");
    end
  end

  typedef struct packed {
    logic [7:0] mask;
    logic isr_sel;
    logic poll;
    logic special_mask_value;
    logic rot_auto;
    logic [2:0] low_prio;
    logic [7:0] eos_clr;
    logic wr_prev;
    logic rd_prev;
    logic [7:0] dout;
    logic dout_oe;
  } ocd_state_s;

  ocd_state_s q;
  ocd_state_s next_q;

  logic wr_act;
  logic rd_act;
  logic wr_take;
  logic rd_end;
  logic [2:0] isr_top;
  logic isr_found;
  logic [2:0] req_top;
  logic req_found;
  logic [7:0] unmasked_req;
  logic [2:0] level;
  logic [1:0] dec;
  ocd_pkg::ocd_cmd_e cmd;

  // A strobe is live only while the chip is selected.
  assign wr_act = ~chip_sel_n & ~wr_n;
  assign rd_act = ~chip_sel_n & ~rd_n;
  // One command per write strobe: a long strobe must not repeat an end of
  // service, so only its first sampled cycle acts.
  assign wr_take = wr_act & ~q.wr_prev & init_done;
  assign rd_end = q.rd_prev & ~rd_act;

  // Field extraction from the host data.
  assign level = din[ocd_pkg::LEVEL_LSB +: ocd_pkg::LEVEL_W];
  assign dec = din[ocd_pkg::DEC_LSB +: 2];
  assign cmd = ocd_pkg::ocd_decode(din);

  // Requests that survive the mask, one gate per level.
  genvar gi;
  generate
    for (gi = 0; gi < N_LEVELS; gi++) begin : g_mask
      assign unmasked_req[gi] = pending_req_reg[gi] & ~q.mask[gi];
    end
  endgenerate

  // Highest in-service level, the target of a non-specific end of service.
  ocd_prio_pick #(
    .WIDTH(N_LEVELS),
    .IDX_W(ocd_pkg::LEVEL_W)
  ) u_isr_pick (
    .vec(in_service_reg),
    .lowest_prio(q.low_prio),
    .top_idx(isr_top),
    .found(isr_found)
  );

  // Highest unmasked pending level, reported by a poll read.
  ocd_prio_pick #(
    .WIDTH(N_LEVELS),
    .IDX_W(ocd_pkg::LEVEL_W)
  ) u_req_pick (
    .vec(unmasked_req),
    .lowest_prio(q.low_prio),
    .top_idx(req_top),
    .found(req_found)
  );

  // Next-state logic for every piece of state in the block.
  always_comb begin
    next_q = q;
    next_q.eos_clr = 8'h00;
    next_q.wr_prev = wr_act;
    next_q.rd_prev = rd_act;

    // Poll mode lasts exactly one read strobe.
    if (rd_end) begin
      next_q.poll = 1'b0;
    end

    if (wr_take) begin
      if (register_select == ocd_pkg::MASK_SELECT_LEVEL) begin
        next_q.mask = din;
      end else if (dec == ocd_pkg::DEC_PRIORITY) begin
        unique case (cmd)
          ocd_pkg::OCD_NS_EOI: begin
            if (isr_found) begin
              next_q.eos_clr[isr_top] = 1'b1;
            end
          end
          ocd_pkg::OCD_SPEC_EOI: begin
            next_q.eos_clr[level] = 1'b1;
          end
          ocd_pkg::OCD_ROT_NS_EOI: begin
            // With nothing in service there is nothing to end or rotate to.
            if (isr_found) begin
              next_q.eos_clr[isr_top] = 1'b1;
              next_q.low_prio = isr_top;
            end
          end
          ocd_pkg::OCD_ROT_AUTO_SET: begin
            next_q.rot_auto = 1'b1;
          end
          ocd_pkg::OCD_ROT_AUTO_CLR: begin
            next_q.rot_auto = 1'b0;
          end
          ocd_pkg::OCD_ROT_SPEC_EOI: begin
            next_q.eos_clr[level] = 1'b1;
            next_q.low_prio = level;
          end
          ocd_pkg::OCD_SPEC_PRIO: begin
            next_q.low_prio = level;
          end
          ocd_pkg::OCD_NOP: begin
            next_q.low_prio = q.low_prio;
          end
        endcase
      end else if (dec == ocd_pkg::DEC_STATUS) begin
        // Bit 7 is ignored; the host keeps it low.
        if (din[ocd_pkg::STATUS_READ_GO_BIT]) begin
          next_q.isr_sel = din[ocd_pkg::ISR_CHOOSE_BIT];
        end
        // A poll entry written in the same cycle a read ends still wins.
        if (din[ocd_pkg::QUERY_BIT] & din[ocd_pkg::STATUS_READ_GO_BIT]) begin
          next_q.poll = 1'b1;
        end
        if (din[ocd_pkg::SPECIAL_MASK_WRITE_EN_BIT]) begin
          next_q.special_mask_value = din[ocd_pkg::SPECIAL_MASK_VALUE_BIT];
        end
      end
    end

    // Read data is registered, so it trails the strobe by one clock. The
    // poll answer is chosen while poll mode still holds during the strobe.
    next_q.dout_oe = rd_act;
    if (register_select == ocd_pkg::MASK_SELECT_LEVEL) begin
      next_q.dout = q.mask;
    end else if (q.poll) begin
      next_q.dout = 8'h00;
      next_q.dout[ocd_pkg::POLL_FLAG_BIT] = req_found;
      next_q.dout[ocd_pkg::LEVEL_LSB +: ocd_pkg::LEVEL_W] = req_top;
    end else if (q.isr_sel) begin
      next_q.dout = in_service_reg;
    end else begin
      next_q.dout = pending_req_reg;
    end
  end

  // State register; reset values are constants only.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.mask <= ocd_pkg::MASK_RESET;
      q.isr_sel <= 1'b0;
      q.poll <= 1'b0;
      q.special_mask_value <= 1'b0;
      q.rot_auto <= 1'b0;
      q.low_prio <= ocd_pkg::LOWEST_PRIO_RESET;
      q.eos_clr <= 8'h00;
      q.wr_prev <= 1'b0;
      q.rd_prev <= 1'b0;
      q.dout <= 8'h00;
      q.dout_oe <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs, all straight from the state register except the gated requests.
  assign interrupt_mask_word = q.mask;
  assign masked_requests = unmasked_req;
  assign in_service_clear = q.eos_clr;
  assign lowest_prio = q.low_prio;
  assign rotate_on_auto_eos = q.rot_auto;
  assign special_mask_mode = q.special_mask_value;
  assign poll_mode = q.poll;
  assign dout = q.dout;
  assign dout_oe = q.dout_oe;

endmodule : ocd_top

// >>> hdl/ocd_pkg.sv
/*
  Shared constants and types for the operation command decoder of an
  eight-level interrupt controller: field positions, decode values, reset
  values and the command enumeration.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package ocd_pkg;

  // Data word shape.
  localparam int DATA_W = 8;
  localparam int LEVEL_W = 3;

  // Priority and end-of-service word fields.
  localparam int LEVEL_LSB = 0;
  localparam int EOI_BIT = 5;
  localparam int USE_LEVEL_BIT = 6;
  localparam int SPIN_BIT = 7;

  // Address decode bits shared by both command words.
  localparam int DEC_LSB = 3;
  localparam logic [1:0] DEC_PRIORITY = 2'h0;
  localparam logic [1:0] DEC_STATUS = 2'h1;

  // Status and mode word fields.
  localparam int ISR_CHOOSE_BIT = 0;
  localparam int STATUS_READ_GO_BIT = 1;
  localparam int QUERY_BIT = 2;
  localparam int SPECIAL_MASK_VALUE_BIT = 5;
  localparam int SPECIAL_MASK_WRITE_EN_BIT = 6;

  // Poll answer: bit 7 flags a pending request, low bits carry its level.
  localparam int POLL_FLAG_BIT = 7;

  // Level of register_select that selects the mask word.
  localparam logic MASK_SELECT_LEVEL = 1'b1;

  // Reset values.
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] LOWEST_PRIO_RESET = 3'h7;

  // Commands carried by bits 7..5 of the priority and end-of-service word.
  typedef enum logic [2:0] {
    OCD_ROT_AUTO_CLR,
    OCD_NS_EOI,
    OCD_NOP,
    OCD_SPEC_EOI,
    OCD_ROT_AUTO_SET,
    OCD_ROT_NS_EOI,
    OCD_SPEC_PRIO,
    OCD_ROT_SPEC_EOI
  } ocd_cmd_e;

  // Maps the spin, use-level and end-of-service bits onto a command.
  function automatic ocd_cmd_e ocd_decode(input logic [7:0] word);
    ocd_cmd_e c;
    c = OCD_NOP;
    unique case ({word[SPIN_BIT], word[USE_LEVEL_BIT], word[EOI_BIT]})
      3'h0: c = OCD_ROT_AUTO_CLR;
      3'h1: c = OCD_NS_EOI;
      3'h2: c = OCD_NOP;
      3'h3: c = OCD_SPEC_EOI;
      3'h4: c = OCD_ROT_AUTO_SET;
      3'h5: c = OCD_ROT_NS_EOI;
      3'h6: c = OCD_SPEC_PRIO;
      3'h7: c = OCD_ROT_SPEC_EOI;
    endcase
    return c;
  endfunction : ocd_decode

endpackage : ocd_pkg

// >>> hdl/ocd_prio_pick.sv
/*
  Rotating priority picker: finds the set bit of highest priority when the
  level just above lowest_prio ranks first and priority falls upward, wrapping.
  Assumes a power-of-two vector width; purely combinational.
*/
`timescale 1ns/1ps
module ocd_prio_pick #(
  parameter int WIDTH = 8,
  parameter int IDX_W = 3
) (
  // Inputs.
  input wire logic [WIDTH-1:0] vec,
  input wire logic [IDX_W-1:0] lowest_prio,
  // Result.
  output logic [IDX_W-1:0] top_idx,
  output logic found
);

  // The modulo wrap below is a plain truncation, so the width must fit.
  initial begin
    if (WIDTH != (1 << IDX_W)) begin
      $error("ocd_prio_pick: WIDTH must be two to the power IDX_W");
    end
  end

  // Walk from the weakest offset to the strongest so the strongest wins.
  always_comb begin
    logic [IDX_W-1:0] cand;
    cand = '0;
    top_idx = '0;
    found = 1'b0;
    for (int k = WIDTH; k >= 1; k--) begin
      cand = IDX_W'(lowest_prio + IDX_W'(k));
      if (vec[cand]) begin
        top_idx = cand;
        found = 1'b1;
      end
    end
  end

endmodule : ocd_prio_pick

// >>> verif/ocd_top_asserts.sv
/* Checker for ocd_top: command word decode, masking and poll exit.
   Assumes it is bound to ocd_top and runs on its one clock and reset. */
`timescale 1ns/1ps
module ocd_top_chk #(
  parameter int N_LEVELS = 8
) (
  // Clock, reset and host side.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic register_select,
  input wire logic init_done,
  input wire logic [7:0] din,
  input wire logic [7:0] pending_req_reg,
  // Decoder outputs.
  input wire logic [7:0] interrupt_mask_word,
  input wire logic [7:0] masked_requests,
  input wire logic [7:0] in_service_clear,
  input wire logic [2:0] lowest_prio,
  input wire logic rotate_on_auto_eos,
  input wire logic special_mask_mode,
  input wire logic poll_mode
);
  logic wr_q, take, cmd, sts, rd_on;
  // A held strobe is one write, so only its first sampled edge counts.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= !chip_sel_n && !wr_n;
    end
  end
  // Decoded write kinds.
  assign take = !chip_sel_n && !wr_n && !wr_q && init_done;
  assign cmd = take && !register_select && din[4:3] == 2'h0;
  assign sts = take && !register_select && din[4:3] == 2'h1;
  assign rd_on = !chip_sel_n && !rd_n;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  property p_mask_wr; take && register_select |=> interrupt_mask_word == $past(din); endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask word");
  property p_masked; masked_requests == (pending_req_reg & ~interrupt_mask_word); endproperty
  a_masked: assert property (p_masked) else $error("masking");
  property p_eoi; cmd && din[7:5] == 3'h3 |=> in_service_clear == 8'h01 << $past(din[2:0]); endproperty
  a_eoi: assert property (p_eoi) else $error("specific end");
  property p_rot; cmd && din[6:5] == 2'h0 |=> rotate_on_auto_eos == $past(din[7]); endproperty
  a_rot: assert property (p_rot) else $error("rotation mode");
  property p_prio; cmd && din[7:6] == 2'h3 |=> lowest_prio == $past(din[2:0]); endproperty
  a_prio: assert property (p_prio) else $error("priority level");
  property p_smm; sts && din[6] |=> special_mask_mode == $past(din[5]); endproperty
  a_smm: assert property (p_smm) else $error("special mask");
  property p_poll_on; sts && din[2:1] == 2'h3 |=> poll_mode; endproperty
  a_poll_on: assert property (p_poll_on) else $error("poll entry");
  property p_poll_off; poll_mode && !rd_on && $past(rd_on) && !take |=> !poll_mode; endproperty
  a_poll_off: assert property (p_poll_off) else $error("poll exit");
endmodule : ocd_top_chk
bind ocd_top ocd_top_chk #(.N_LEVELS(N_LEVELS)) u_chk (.ref_clk, .sys_rst, .chip_sel_n, .wr_n, .rd_n,
  .register_select, .init_done, .din, .pending_req_reg, .interrupt_mask_word, .masked_requests,
  .in_service_clear, .lowest_prio, .rotate_on_auto_eos, .special_mask_mode, .poll_mode);

// >>> verif/ocd_host_model.sv
/* Host processor model for the decoder port: one write or read per call.
   Assumes calls come one at a time from the bench on a 100 ns clock. */
`timescale 1ns/1ps
module ocd_host_model (
  // Clock and read data.
  input wire logic ref_clk,
  input wire logic [7:0] dout,
  // Strobes, select and write data.
  output logic chip_sel_n,
  output logic wr_n,
  output logic rd_n,
  output logic register_select,
  output logic [7:0] din
);
  // Idle bus at time zero.
  initial {chip_sel_n, wr_n, rd_n, register_select, din} = 12'hE00;
  // Held to its sampling edge, then released; a freed bus shows inverted data so stale bytes never pass.
  task automatic xfer(input logic wr, input logic rs, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    {chip_sel_n, wr_n, rd_n} = {1'b0, !wr, wr};
    register_select = rs;
    din = d;
    @(posedge ref_clk);
    #1;
    q = dout;
    {chip_sel_n, wr_n, rd_n} = 3'h7;
    din = ~d;
  endtask : xfer
endmodule : ocd_host_model

// >>> verif/ocd_top_tb.sv
/* Self-checking bench for ocd_top: random command words and reads against a model.
   Assumes the host model and the bound checker are compiled with the design. */
`timescale 1ns/1ps
module ocd_top_tb;
  logic ref_clk, sys_rst, init_done, chip_sel_n, wr_n, rd_n, register_select, dout_oe;
  logic rotate_on_auto_eos, special_mask_mode, poll_mode, rot, special_mask_value, poll, rsel;
  logic [7:0] din, dout, pending_req_reg, in_service_reg, interrupt_mask_word, masked_requests;
  logic [7:0] in_service_clear, q, v;
  logic [2:0] lowest_prio;
  int error_cnt, checks_done, seed, mask, lp, ecl, e, t, r;
  // Device and the host driving its port.
  ocd_top dut (.ref_clk, .sys_rst, .chip_sel_n, .wr_n, .rd_n, .register_select, .din, .dout, .dout_oe,
    .init_done, .pending_req_reg, .in_service_reg, .interrupt_mask_word, .masked_requests,
    .in_service_clear, .lowest_prio, .rotate_on_auto_eos, .special_mask_mode, .poll_mode);
  ocd_host_model host (.ref_clk, .dout, .chip_sel_n, .wr_n, .rd_n, .register_select, .din);
  // Free-running 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Four-state compare, so an unknown never matches.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (exp !== got) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One access, the model's reaction, then the outputs compared; dout and dout_oe only on reads.
  task automatic op(input logic wr, input logic rs, input logic [7:0] w);
    v = wr ? in_service_reg : pending_req_reg & ~mask[7:0];
    t = -1;
    ecl = 0;
    for (int i = 8; i > 0; i--) begin
      if (v[(lp + i) % 8]) t = (lp + i) % 8;
    end
    e = rs ? mask : !poll ? (rsel ? in_service_reg : pending_req_reg) : t < 0 ? 0 : 8'h80 | t;
    host.xfer(wr, rs, w, q);
    if (!wr) begin
      chk("dout", e[7:0], q);
      chk("oe", 8'h01, {7'h0, dout_oe});
      poll = 1'b0;
      @(posedge ref_clk);
      #1;
      chk("oe_off", 8'h00, {7'h0, dout_oe});
    end else if (init_done && rs) begin
      mask = w;
    end else if (init_done && w[4:3] == 2'h0) begin
      case (w[7:5])
        3'h0, 3'h4: rot = w[7];
        3'h1, 3'h5: begin
          ecl = t < 0 ? 0 : 1 << t;
          if (w[7] && t >= 0) lp = t;
        end
        3'h2: ecl = 0;
        default: begin
          ecl = int'(w[5]) << w[2:0];
          if (w[7]) lp = w[2:0];
        end
      endcase
    end else if (init_done && w[4:3] == 2'h1) begin
      if (w[1]) rsel = w[0];
      if (w[2] && w[1]) poll = 1'b1;
      if (w[6]) special_mask_value = w[5];
    end
    chk("mask", mask[7:0], interrupt_mask_word);
    chk("masked", pending_req_reg & ~mask[7:0], masked_requests);
    chk("clear", ecl[7:0], in_service_clear);
    chk("prio", lp[7:0], {5'h0, lowest_prio});
    chk("modes", {5'h0, rot, special_mask_value, poll}, {5'h0, rotate_on_auto_eos, special_mask_mode, poll_mode});
  endtask : op
  // Counts, verdict, end of run.
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Reset, a write refused before init_done, then random traffic.
  initial begin
    {sys_rst, init_done, rot, special_mask_value, poll, rsel, pending_req_reg, in_service_reg} = 22'h20A500;
    {error_cnt, checks_done, mask, ecl} = 128'h0;
    seed = 19;
    lp = 7;
    repeat (12) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    op(1'b0, 1'b0, 8'h00);
    op(1'b1, 1'b1, 8'hFF);
    init_done = 1'b1;
    for (int n = 0; n < 400; n++) begin
      r = $random(seed);
      {in_service_reg, pending_req_reg} = r[23:8];
      case (r[25:24])
        2'h0: op(1'b1, 1'b1, r[7:0]);
        2'h1: op(1'b1, 1'b0, {r[7:5], r[4] & r[26], 1'b0, r[2:0]});
        2'h2: op(1'b1, 1'b0, {1'b0, r[6:5], 2'h1, r[2:0]});
        default: op(1'b0, r[27], 8'h00);
      endcase
    end
    summarize();
  end
endmodule : ocd_top_tb
